// ### core/ssw_top.sv
// Operation
// - After power-on the system reset is held for the selected hold time, then released.
// - The hold time is one of 50, 200, 400 or 800 ms and applies after every release.
// - A low main supply asserts reset until it recovers and the hold time has passed.
// - Without a restart inside the selected interval the watchdog alarm goes active.
// - The watchdog interval is 25 ms, 200 ms, 1.4 s, or off.
// - The selected watchdog interval is kept in non-volatile storage across power loss.
// - The manual reset input is debounced before it reaches the reset output.
// - A low manual reset holds reset while low and for the hold time after release.
// - The second fail output follows its comparator, low when below, with no delay.
// - The early supply-low output follows the main comparator with no hold delay.
// - The third fail output follows its comparator, low when below, with no delay.
// - A data fall, a clock fall and then a stop condition restart the watchdog.
// - The watchdog alarm is active low and asserts whenever the timer expired.
// - The reset output has an active-low and an active-high build, same conditions.
`timescale 1ns/100ps
module ssw_top #(
  parameter logic [15:0] TICK_CYCLES      = ssw_pkg::TICK_CYCLES,
  parameter logic        RESET_ACTIVE_LOW = 1'b1
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       MAIN_SUPPLY_LOW,
  input  wire logic       AUX2_SENSE_IN,
  input  wire logic       AUX3_SENSE_IN,
  input  wire logic       MANUAL_RESET_REQUEST_N,
  input  wire logic       SCL,
  input  wire logic       SDA,
  input  wire logic [1:0] POR_SEL,
  input  wire logic [1:0] NV_WDT_SEL,
  input  wire logic [1:0] WDT_SEL_IN,
  input  wire logic       WDT_SEL_WE,
  output logic            SYS_RESET_OUT,
  output logic            EARLY_SUPPLY_LOW_OUT,
  output logic            AUX2_FAIL_OUT,
  output logic            AUX3_FAIL_OUT,
  output logic            WATCHDOG_ALARM_N,
  output logic            NV_WDT_SEL_WR,
  output logic [1:0]      NV_WDT_SEL_DATA
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssw_pkg::ssw_sense_s             sense_meta;
  ssw_pkg::ssw_sense_s             sense;
  logic [15:0]                     pre_cnt;
  logic                            tick;
  logic                            mr_clean;
  logic                            init_done;
  logic [1:0]                      por_sel;
  logic [1:0]                      wdt_sel;
  logic [ssw_pkg::TICK_W-1:0]      hold_cnt;
  logic [ssw_pkg::TICK_W-1:0]      hold_limit;
  ssw_pkg::ssw_rst_e               state;
  ssw_pkg::ssw_rst_e               next_state;
  logic                            cause;
  logic                            scl_q;
  logic                            sda_q;
  ssw_pkg::ssw_wseq_e              wseq;
  ssw_pkg::ssw_wseq_e              next_wseq;
  logic                            wd_restart;
  logic                            wd_enabled;
  logic [ssw_pkg::TICK_W-1:0]      wd_cnt;
  logic [ssw_pkg::TICK_W-1:0]      wd_limit;
  logic                            wd_expire;
  logic                            wd_alarm;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      pre_cnt <= '0;
      tick    <= 1'b0;
    end else if (pre_cnt == TICK_CYCLES - 16'h0001) begin
      pre_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Reset values treat the supply as low, so power-up starts in reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      sense_meta <= ssw_pkg::SENSE_RST;
      sense      <= ssw_pkg::SENSE_RST;
    end else begin
      sense_meta <= '{main_low:   MAIN_SUPPLY_LOW,
                      aux2_above: AUX2_SENSE_IN,
                      aux3_above: AUX3_SENSE_IN,
                      mr_n:       MANUAL_RESET_REQUEST_N};
      sense      <= sense_meta;
    end
  end

  ssw_debounce u_mr_debounce (
    .clk       (CLK),
    .rst       (RST),
    .tick      (tick),
    .level_in  (sense.mr_n),
    .level_out (mr_clean)
  );

  // ----------------------------------------------------------------
  // Monitor outputs, one register stage after synchronisation, no hold delay
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      EARLY_SUPPLY_LOW_OUT <= 1'b0;
      AUX2_FAIL_OUT        <= 1'b0;
      AUX3_FAIL_OUT        <= 1'b0;
    end else begin
      EARLY_SUPPLY_LOW_OUT <= ~sense.main_low;
      AUX2_FAIL_OUT        <= sense.aux2_above;
      AUX3_FAIL_OUT        <= sense.aux3_above;
    end
  end

  // ----------------------------------------------------------------
  // Selections, captured once after reset release
  // ----------------------------------------------------------------
  // Interval lives in the non-volatile cell; a write is sent out to it
  always_ff @(posedge CLK) begin
    if (RST) begin
      init_done       <= 1'b0;
      por_sel         <= ssw_pkg::POR_SEL_RST;
      wdt_sel         <= ssw_pkg::WDT_SEL_RST;
      NV_WDT_SEL_WR   <= 1'b0;
      NV_WDT_SEL_DATA <= ssw_pkg::WDT_SEL_RST;
    end else if (!init_done) begin
      init_done       <= 1'b1;
      por_sel         <= POR_SEL;
      wdt_sel         <= NV_WDT_SEL;
      NV_WDT_SEL_WR   <= 1'b0;
      NV_WDT_SEL_DATA <= NV_WDT_SEL;
    end else if (WDT_SEL_WE) begin
      wdt_sel         <= WDT_SEL_IN;
      NV_WDT_SEL_WR   <= 1'b1;
      NV_WDT_SEL_DATA <= WDT_SEL_IN;
    end else begin
      NV_WDT_SEL_WR   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System reset sequencer
  // ----------------------------------------------------------------
  assign hold_limit = ssw_pkg::por_ticks(por_sel);
  assign cause      = sense.main_low | ~mr_clean;

  always_comb begin
    next_state = state;
    case (state)
      ssw_pkg::ST_HOLD: begin
        if (!cause && hold_cnt >= hold_limit) begin
          next_state = ssw_pkg::ST_RUN;
        end
      end
      ssw_pkg::ST_RUN: begin
        if (cause) begin
          next_state = ssw_pkg::ST_HOLD;
        end
      end
      default: next_state = ssw_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ssw_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Any cause restarts the full hold, so bounce cannot shorten it
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_cnt <= '0;
    end else if (cause || state == ssw_pkg::ST_RUN) begin
      hold_cnt <= '0;
    end else if (tick && hold_cnt < hold_limit) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SYS_RESET_OUT <= ~RESET_ACTIVE_LOW;
    end else begin
      SYS_RESET_OUT <= (next_state == ssw_pkg::ST_HOLD) ^
                       RESET_ACTIVE_LOW;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog restart sequence on the serial pins
  // ----------------------------------------------------------------
  assign wd_enabled = (wdt_sel != ssw_pkg::WDT_SEL_OFF);

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= SCL;
      sda_q <= SDA;
    end
  end

  always_comb begin
    next_wseq  = wseq;
    wd_restart = 1'b0;
    case (wseq)
      ssw_pkg::WS_IDLE: begin
        if (ssw_pkg::fell(sda_q, SDA) && SCL) begin
          next_wseq = ssw_pkg::WS_SDA_FELL;
        end
      end
      ssw_pkg::WS_SDA_FELL: begin
        if (ssw_pkg::fell(scl_q, SCL)) begin
          next_wseq = ssw_pkg::WS_SCL_FELL;
        end
      end
      ssw_pkg::WS_SCL_FELL: begin
        if (ssw_pkg::rose(sda_q, SDA) && SCL) begin
          next_wseq  = ssw_pkg::WS_IDLE;
          wd_restart = 1'b1;
        end else if (ssw_pkg::fell(sda_q, SDA) && SCL) begin
          next_wseq = ssw_pkg::WS_SDA_FELL;
        end
      end
      default: next_wseq = ssw_pkg::WS_IDLE;
    endcase
    if (!wd_enabled) begin
      next_wseq  = ssw_pkg::WS_IDLE;
      wd_restart = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wseq <= ssw_pkg::WS_IDLE;
    end else begin
      wseq <= next_wseq;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog timer and alarm
  // ----------------------------------------------------------------
  assign wd_limit  = ssw_pkg::wdt_ticks(wdt_sel);
  // Expiry is the one tick that reaches the limit, so a later restart clears
  assign wd_expire = wd_enabled && state == ssw_pkg::ST_RUN && tick &&
                     wd_cnt == wd_limit - 1'b1;

  // Timer idles while the host is held in reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      wd_cnt <= '0;
    end else if (!wd_enabled || state != ssw_pkg::ST_RUN || wd_restart) begin
      wd_cnt <= '0;
    end else if (tick && wd_cnt < wd_limit) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // Expiry wins over a restart in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      wd_alarm <= 1'b0;
    end else if (!wd_enabled) begin
      wd_alarm <= 1'b0;
    end else if (wd_expire) begin
      wd_alarm <= 1'b1;
    end else if (wd_restart) begin
      wd_alarm <= 1'b0;
    end
  end

  assign WATCHDOG_ALARM_N = ~wd_alarm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence hold_done_s;
    state == ssw_pkg::ST_HOLD && !cause;
  endsequence

  sequence released_s;
    state == ssw_pkg::ST_RUN;
  endsequence

  property release_after_hold_p;
    @(posedge CLK) disable iff (RST)
    hold_done_s ##1 released_s |->
      $past(hold_cnt) >= $past(hold_limit);
  endproperty

  por_release_a: assert property (release_after_hold_p)
    else $error("Reset released before the hold time");

  hold_table_a: assert property (
    @(posedge CLK) disable iff (RST)
    por_sel == ssw_pkg::POR_SEL_800MS |-> hold_limit == 11'h320)
    else $error("Hold limit wrong for 800 ms");

  supply_reset_a: assert property (
    @(posedge CLK) disable iff (RST)
    sense.main_low |=> SYS_RESET_OUT != RESET_ACTIVE_LOW)
    else $error("Low supply did not assert reset");

  wdt_expire_a: assert property (
    @(posedge CLK) disable iff (RST)
    wd_expire |=> !WATCHDOG_ALARM_N)
    else $error("Watchdog expiry did not raise alarm");

  wdt_interval_a: assert property (
    @(posedge CLK) disable iff (RST)
    wdt_sel == ssw_pkg::WDT_SEL_1400MS |-> wd_limit == 11'h578)
    else $error("Watchdog limit wrong for 1.4 s");

  nv_retain_a: assert property (
    @(posedge CLK) disable iff (RST)
    init_done && !WDT_SEL_WE |=> $stable(wdt_sel))
    else $error("Watchdog selection changed without write");

  manual_hold_a: assert property (
    @(posedge CLK) disable iff (RST)
    !mr_clean |=> SYS_RESET_OUT != RESET_ACTIVE_LOW)
    else $error("Manual reset did not hold reset");

  aux2_follow_a: assert property (
    @(posedge CLK) disable iff (RST)
    AUX2_FAIL_OUT == $past(sense.aux2_above))
    else $error("Second fail output does not follow input");

  early_low_a: assert property (
    @(posedge CLK) disable iff (RST)
    EARLY_SUPPLY_LOW_OUT == !$past(sense.main_low))
    else $error("Early supply-low output does not follow");

  aux3_follow_a: assert property (
    @(posedge CLK) disable iff (RST)
    AUX3_FAIL_OUT == $past(sense.aux3_above))
    else $error("Third fail output does not follow input");

  restart_clear_a: assert property (
    @(posedge CLK) disable iff (RST)
    wd_restart |=> wd_cnt == '0)
    else $error("Restart did not clear watchdog count");

  polarity_a: assert property (
    @(posedge CLK) disable iff (RST)
    $past(state) == ssw_pkg::ST_RUN && state == ssw_pkg::ST_RUN |->
      SYS_RESET_OUT == RESET_ACTIVE_LOW)
    else $error("Reset output polarity wrong while running");

  wdt_off_a: assert property (
    @(posedge CLK) disable iff (RST)
    !wd_enabled |=> WATCHDOG_ALARM_N && wd_cnt == '0)
    else $error("Watchdog active while disabled");

endmodule

// ### shared/ssw_pkg.sv
package ssw_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
  localparam int unsigned TICK_TIME_US  = 1000;
  localparam int unsigned TICK_CYC_INT  =
    (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
  localparam logic [15:0] TICK_CYCLES   = 16'(TICK_CYC_INT);

  // ----------------------------------------------------------------
  // Durations in ms and their tick counts (rounded up)
  // ----------------------------------------------------------------
  localparam int unsigned POR_TIME0_MS  = 50;
  localparam int unsigned POR_TIME1_MS  = 200;
  localparam int unsigned POR_TIME2_MS  = 400;
  localparam int unsigned POR_TIME3_MS  = 800;
  localparam int unsigned WDT_TIME0_MS  = 25;
  localparam int unsigned WDT_TIME1_MS  = 200;
  localparam int unsigned WDT_TIME2_MS  = 1400;
  localparam int unsigned DEBOUNCE_MS   = 10;

  localparam int unsigned TICK_W        = 11;
  localparam int unsigned DB_W          = 4;

  function automatic logic [TICK_W-1:0] ms_to_ticks(int unsigned ms);
    ms_to_ticks = TICK_W'((ms * 1000 + TICK_TIME_US - 1) / TICK_TIME_US);
  endfunction

  localparam logic [DB_W-1:0] DEBOUNCE_TICKS =
    DB_W'((DEBOUNCE_MS * 1000 + TICK_TIME_US - 1) / TICK_TIME_US);

  // ----------------------------------------------------------------
  // Selector encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] POR_SEL_50MS   = 2'h0;
  localparam logic [1:0] POR_SEL_200MS  = 2'h1;
  localparam logic [1:0] POR_SEL_400MS  = 2'h2;
  localparam logic [1:0] POR_SEL_800MS  = 2'h3;
  localparam logic [1:0] WDT_SEL_25MS   = 2'h0;
  localparam logic [1:0] WDT_SEL_200MS  = 2'h1;
  localparam logic [1:0] WDT_SEL_1400MS = 2'h2;
  localparam logic [1:0] WDT_SEL_OFF    = 2'h3;
  localparam logic [1:0] POR_SEL_RST    = POR_SEL_50MS;
  localparam logic [1:0] WDT_SEL_RST    = WDT_SEL_25MS;

  function automatic logic [TICK_W-1:0] por_ticks(logic [1:0] sel);
    case (sel)
      POR_SEL_50MS:  por_ticks = ms_to_ticks(POR_TIME0_MS);
      POR_SEL_200MS: por_ticks = ms_to_ticks(POR_TIME1_MS);
      POR_SEL_400MS: por_ticks = ms_to_ticks(POR_TIME2_MS);
      default:       por_ticks = ms_to_ticks(POR_TIME3_MS);
    endcase
  endfunction

  function automatic logic [TICK_W-1:0] wdt_ticks(logic [1:0] sel);
    case (sel)
      WDT_SEL_25MS:   wdt_ticks = ms_to_ticks(WDT_TIME0_MS);
      WDT_SEL_200MS:  wdt_ticks = ms_to_ticks(WDT_TIME1_MS);
      default:        wdt_ticks = ms_to_ticks(WDT_TIME2_MS);
    endcase
  endfunction

  function automatic logic fell(logic prev, logic cur);
    fell = prev & ~cur;
  endfunction

  function automatic logic rose(logic prev, logic cur);
    rose = ~prev & cur;
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_HOLD = 1'b0,
    ST_RUN  = 1'b1
  } ssw_rst_e;

  typedef enum logic [1:0] {
    WS_IDLE     = 2'b00,
    WS_SDA_FELL = 2'b01,
    WS_SCL_FELL = 2'b10
  } ssw_wseq_e;

  typedef struct packed {
    logic main_low;
    logic aux2_above;
    logic aux3_above;
    logic mr_n;
  } ssw_sense_s;

  localparam ssw_sense_s SENSE_RST = '{
    main_low: 1'b1, aux2_above: 1'b0, aux3_above: 1'b0, mr_n: 1'b1};

endpackage

// ### core/ssw_debounce.sv
`timescale 1ns/100ps
module ssw_debounce (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic level_in,
  output logic      level_out
);

  logic [ssw_pkg::DB_W-1:0] cnt;

  // ----------------------------------------------------------------
  // Level must sit unchanged for the whole window
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt       <= '0;
      level_out <= 1'b1;
    end else if (level_in == level_out) begin
      cnt <= '0;
    end else if (tick) begin
      if (cnt == ssw_pkg::DEBOUNCE_TICKS - 1'b1) begin
        cnt       <= '0;
        level_out <= level_in;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  debounce_tick_a: assert property (
    @(posedge clk) disable iff (rst)
    $changed(level_out) |-> $past(tick) && $past(level_in) == level_out)
    else $error("Debounced level changed off a tick");

endmodule

// ### test/ssw_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host side restart driver
// ----------------------------------------------------------------
module ssw_host_model (
  input  wire logic clk,
  output logic      scl,
  output logic      sda
);
  // Pulled-up lines rest high outside a restart
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic step(input int gap);
    repeat (gap) @(posedge clk);
    #1;
  endtask

  // Gap sets a prompt or a slow host
  task automatic restart(input int gap);
    step(1);
    sda = 1'b0;
    step(gap);
    scl = 1'b0;
    step(gap);
    scl = 1'b1;
    step(gap);
    sda = 1'b1;
    step(1);
  endtask
endmodule

// ### test/ssw_top_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module ssw_top_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TK = 4;
  logic       clk      = 1'b0;
  logic       rst      = 1'b1;
  logic       main_low = 1'b0;
  logic       aux2     = 1'b1;
  logic       aux3     = 1'b1;
  logic       mr_n     = 1'b1;
  logic [1:0] por_sel  = 2'h0;
  logic [1:0] nv_sel   = 2'h0;
  logic [1:0] wsel     = 2'h0;
  logic       wsel_we  = 1'b0;
  logic       scl;
  logic       sda;
  logic       sys_rst;
  logic       rst_hi;
  logic       early_hi;
  logic       a2f_hi;
  logic       alarm_hi;
  logic       early;
  logic       a2f;
  logic       a3f;
  logic       alarm_n;
  logic       nv_wr;
  logic [1:0] nv_data;
  int         err_total = 0;
  int         cmp_count = 0;
  int         hold_tbl [4] = '{50, 200, 400, 800};
  int         wdt_tbl  [3] = '{25, 200, 1400};

  // ----------------------------------------------------------------
  // Design, high-polarity twin, host and cell
  // ----------------------------------------------------------------
  ssw_top #(.TICK_CYCLES(16'h0004)) u_ssw_top (
    .CLK(clk), .RST(rst), .MAIN_SUPPLY_LOW(main_low),
    .AUX2_SENSE_IN(aux2), .AUX3_SENSE_IN(aux3),
    .MANUAL_RESET_REQUEST_N(mr_n), .SCL(scl), .SDA(sda),
    .POR_SEL(por_sel), .NV_WDT_SEL(nv_sel), .WDT_SEL_IN(wsel),
    .WDT_SEL_WE(wsel_we), .SYS_RESET_OUT(sys_rst),
    .EARLY_SUPPLY_LOW_OUT(early), .AUX2_FAIL_OUT(a2f),
    .AUX3_FAIL_OUT(a3f), .WATCHDOG_ALARM_N(alarm_n),
    .NV_WDT_SEL_WR(nv_wr), .NV_WDT_SEL_DATA(nv_data));
  // Same stimulus, other build; only the reset polarity may differ
  ssw_top #(.TICK_CYCLES(16'h0004), .RESET_ACTIVE_LOW(1'b0)) u_ssw_top_hi (
    .CLK(clk), .RST(rst), .MAIN_SUPPLY_LOW(main_low),
    .AUX2_SENSE_IN(aux2), .AUX3_SENSE_IN(aux3),
    .MANUAL_RESET_REQUEST_N(mr_n), .SCL(scl), .SDA(sda),
    .POR_SEL(por_sel), .NV_WDT_SEL(nv_sel), .WDT_SEL_IN(wsel),
    .WDT_SEL_WE(wsel_we), .SYS_RESET_OUT(rst_hi),
    .EARLY_SUPPLY_LOW_OUT(early_hi), .AUX2_FAIL_OUT(a2f_hi),
    .AUX3_FAIL_OUT(), .WATCHDOG_ALARM_N(alarm_hi),
    .NV_WDT_SEL_WR(), .NV_WDT_SEL_DATA());
  ssw_host_model u_ssw_host_model (.clk(clk), .scl(scl), .sda(sda));

  // Cell keeps its contents across power_up
  always @(posedge clk) begin
    if (nv_wr) begin
      nv_sel <= nv_data;
    end
  end

  initial begin
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic power_up(input logic [1:0] sel);
    rst = 1'b1;
    por_sel = sel;
    cyc(20);
    rst = 1'b0;
  endtask

  task automatic chk_rst(input logic act);
    `CHK(sys_rst, ~act)
    `CHK(rst_hi, act)
    `CHK(early_hi, early)
    `CHK(a2f_hi, a2f)
    `CHK(alarm_hi, alarm_n)
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_por();
    for (int i = 0; i < 4; i++) begin
      power_up(2'(i));
      cyc(hold_tbl[i] * TK - 8);
      chk_rst(1'b1);
      cyc(24);
      chk_rst(1'b0);
    end
    $display("test por done");
  endtask

  task automatic t_mon();
    power_up(2'h0);
    cyc(hold_tbl[0] * TK + 16);
    aux2 = 1'b0;
    main_low = 1'b1;
    cyc(1);
    `CHK(a2f, 1'b1)
    cyc(3);
    `CHK(a2f, 1'b0)
    `CHK(early, 1'b0)
    chk_rst(1'b1);
    aux2 = 1'b1;
    aux3 = 1'b0;
    main_low = 1'b0;
    cyc(4);
    `CHK(a2f, 1'b1)
    `CHK(a3f, 1'b0)
    `CHK(early, 1'b1)
    aux3 = 1'b1;
    cyc(hold_tbl[0] * TK - 12);
    `CHK(a3f, 1'b1)
    chk_rst(1'b1);
    cyc(24);
    chk_rst(1'b0);
    $display("test monitors done");
  endtask

  task automatic t_mr();
    // Short bounce is far below the ten-tick window
    mr_n = 1'b0;
    cyc(5);
    mr_n = 1'b1;
    cyc(60);
    chk_rst(1'b0);
    mr_n = 1'b0;
    cyc(20 * TK);
    chk_rst(1'b1);
    cyc(100);
    chk_rst(1'b1);
    mr_n = 1'b1;
    cyc((10 + hold_tbl[0]) * TK - 12);
    chk_rst(1'b1);
    cyc(36);
    chk_rst(1'b0);
    $display("test manual done");
  endtask

  task automatic t_wd();
    repeat (4) begin
      u_ssw_host_model.restart(1);
      cyc(60);
      `CHK(alarm_n, 1'b1)
    end
    u_ssw_host_model.restart(3);
    cyc(wdt_tbl[0] * TK - 12);
    `CHK(alarm_n, 1'b1)
    cyc(24);
    `CHK(alarm_n, 1'b0)
    cyc(200);
    `CHK(alarm_n, 1'b0)
    u_ssw_host_model.restart(2);
    cyc(4);
    `CHK(alarm_n, 1'b1)
    $display("test watchdog done");
  endtask

  task automatic t_sel();
    for (int i = 0; i < 4; i++) begin
      wsel = 2'(i);
      wsel_we = 1'b1;
      cyc(1);
      wsel_we = 1'b0;
      `CHK(nv_wr, 1'b1)
      `CHK(nv_data, 2'(i))
      cyc(1);
      `CHK(nv_wr, 1'b0)
      u_ssw_host_model.restart(1);
      `CHK(alarm_n, 1'b1)
      if (i < 3) begin
        cyc(wdt_tbl[i] * TK - 12);
        `CHK(alarm_n, 1'b1)
        cyc(24);
        `CHK(alarm_n, 1'b0)
      end else begin
        cyc(1500 * TK);
        `CHK(alarm_n, 1'b1)
      end
    end
    $display("test interval done");
  endtask

  task automatic t_nv();
    // Off setting must survive, default would alarm here
    power_up(2'h0);
    cyc(2);
    `CHK(nv_data, 2'h3)
    cyc(hold_tbl[0] * TK + 200);
    `CHK(alarm_n, 1'b1)
    $display("test retention done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    t_por();
    t_mon();
    t_mr();
    t_wd();
    t_sel();
    t_nv();
    test_done();
  end

  // Roughly twice the expected run length
  initial begin
    repeat (45000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
